// ==== usb_fctl_consts.vh ====
// Constants for the function address and power control block
// How it works
// - Software writes a 7-bit address; it takes effect when the transfer ends.
// - Address register bit 7 reads 1 after a write until the address applies.
// - Bus reset detection sets the reset-detect flag, power bit 3.
// - Bus reset clears the function address to zero.
// - Bus reset flushes every endpoint FIFO.
// - Bus reset clears all endpoint control/status registers to zero.
// - Bus reset clears the endpoint index register to zero.
// - Bus reset enables all interrupts but suspend and clears their flags.
// - Bus reset raises the reset interrupt flag without checking its enable bit.
// - Writing 1 to the reset bit resets the whole function to defaults.
// - With suspend detection on, bus suspend enters suspend and flags it when enabled.
// - Resume or bus reset wakes the oscillator; bus reset or any reset leaves suspend.
// - Host resume raises the resume flag when enabled; suspend ends at the next interrupt flag read.
// - Power bit 2 drives remote wakeup only while suspended; software clears it after 10-15 ms.
// - With iso update set, newly loaded iso IN packets wait for next SOF.
// - With iso update set, an iso IN token before SOF gets a zero packet.
// - Inhibit reads 1 after reset; once cleared only a reset sets it again.
// - While inhibit is 1, bus reset, suspend, resume and iso traffic are ignored; power bit 3 and transfer end still act.
// - Suspend status reads 1 while suspended; cleared on resume end or read.
`ifndef USB_FCTL_CONSTS_VH
`define USB_FCTL_CONSTS_VH
`define ADDR_FUNC 12'h000
`define ADDR_POWER 12'h004
`define ADDR_INTEN 12'h008
`define ADDR_IRQF 12'h00C
`define ADDR_STAT 12'h010
`define FUNC_RESET 8'h00
`define POWER_RESET 8'h10
`define INTEN_RESET 8'h00
`define INTEN_BUSRST 8'h06
`define PWR_SUSPEND_DETECT_ENABLE 0
`define PWR_SUSPEND_STATUS 1
`define PWR_RESUME 2
`define PWR_BUSRST 3
`define PWR_INHIBIT 4
`define PWR_ISO 7
`define FUNC_PEND 7
`define IRQ_SUSP 0
`define IRQ_RESUME 1
`define IRQ_RESET 2
`endif

// ==== usb_function_address_power_control.v ====
// Function address, power, suspend and reset control with AXI4-Lite slave
`timescale 1ns/1ps
`include "usb_fctl_consts.vh"

module usb_function_address_power_control (
  input wire MCLK_I,
  input wire RESET_N_I,
  input wire [11:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output reg S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output reg S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [11:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output reg S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire BUS_RESET_I,
  input wire BUS_SUSPEND_I,
  input wire BUS_RESUME_I,
  input wire TRANSFER_DONE_I,
  input wire SOF_I,
  input wire ISO_IN_TOKEN_I,
  input wire IN_PACKET_LOADED_I,
  output reg [6:0] ACTIVE_ADDRESS_O,
  output reg FUNCTION_ENABLE_O,
  output reg SUSPENDED_O,
  output reg OSC_WAKE_O,
  output reg REMOTE_WAKEUP_O,
  output reg ISO_SEND_PACKET_O,
  output reg ISO_ZERO_LENGTH_O,
  output reg FIFO_FLUSH_O,
  output reg EP_CSR_CLEAR_O,
  output reg INDEX_CLEAR_O
);

  // ------------------------------------------------------------
  // Pin synchronisers, three stages, edge once stages 2 and 3 agree
  // ------------------------------------------------------------
  wire [2:0] pin_raw = {BUS_RESUME_I, BUS_SUSPEND_I, BUS_RESET_I};
  reg [2:0] sync1;
  reg [2:0] sync2;
  reg [2:0] sync3;
  reg [2:0] pin_level;
  wire [2:0] pin_rise;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_sync
      always @(posedge MCLK_I or negedge RESET_N_I)
      begin
        if (!RESET_N_I)
        begin
          sync1[g] <= 1'b0;
          sync2[g] <= 1'b0;
          sync3[g] <= 1'b0;
          pin_level[g] <= 1'b0;
        end
        else
        begin
          sync1[g] <= pin_raw[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          if (sync2[g] == sync3[g])
            pin_level[g] <= sync3[g];
        end
      end
      assign pin_rise[g] = (sync2[g] == sync3[g]) && sync3[g] &&
        !pin_level[g];
    end
  endgenerate
  wire bus_reset_evt = pin_rise[0];
  wire suspend_evt = pin_rise[1];
  wire resume_evt = pin_rise[2];

  // ------------------------------------------------------------
  // Software reset: asynchronous, from a flop released next cycle
  // ------------------------------------------------------------
  // The reset pulse comes from a register so the async path is glitch free.
  reg soft_reset;
  wire rst_n = RESET_N_I & ~soft_reset;

  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  // Word registers: the two low address bits are ignored on decode
  localparam [11:0] ofs_func = `ADDR_FUNC;
  localparam [11:0] ofs_power = `ADDR_POWER;
  localparam [11:0] ofs_inten = `ADDR_INTEN;
  localparam [11:0] ofs_irqf = `ADDR_IRQF;
  localparam [11:0] ofs_stat = `ADDR_STAT;

  // ------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [9:0] wr_idx = aw_addr[11:2];
  wire [9:0] rd_idx = S_AXI_ARADDR_I[11:2];
  wire wr_go = aw_held && w_held && !S_AXI_BVALID_O;
  wire wr_lane0 = wr_go && w_strb[0];
  wire wr_func = wr_lane0 && (wr_idx == ofs_func[11:2]);
  wire wr_power = wr_lane0 && (wr_idx == ofs_power[11:2]);
  wire wr_inten = wr_lane0 && (wr_idx == ofs_inten[11:2]);
  wire wr_hit = (wr_idx == ofs_func[11:2]) ||
    (wr_idx == ofs_power[11:2]) ||
    (wr_idx == ofs_inten[11:2]) ||
    (wr_idx == ofs_irqf[11:2]) ||
    (wr_idx == ofs_stat[11:2]);
  wire rd_go = S_AXI_ARVALID_I && S_AXI_ARREADY_O;
  wire rd_irqf = rd_go && (rd_idx == ofs_irqf[11:2]);

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  reg [6:0] addr_written;
  reg addr_pending;
  reg iso_enable;
  reg inhibit;
  reg busrst_flag;
  reg resume_drive;
  reg suspend_mode;
  reg suspend_enable;
  reg [7:0] int_enable;
  reg [7:0] irq_flags;
  reg resumed_by_host;
  reg iso_waiting;
  reg [7:0] rdata_mux;

  always @*
  begin
    rdata_mux = 8'h00;
    case (rd_idx)
      ofs_func[11:2]: rdata_mux = {addr_pending, addr_written};
      ofs_power[11:2]: rdata_mux = {iso_enable, 2'b00, inhibit,
        busrst_flag, resume_drive, suspend_mode, suspend_enable};
      ofs_inten[11:2]: rdata_mux = int_enable;
      ofs_irqf[11:2]: rdata_mux = irq_flags;
      ofs_stat[11:2]: rdata_mux = {5'h00, iso_waiting, pin_level[1],
        FUNCTION_ENABLE_O};
      default: rdata_mux = 8'h00;
    endcase
  end

  wire rd_hit = (rd_idx == ofs_func[11:2]) ||
    (rd_idx == ofs_power[11:2]) ||
    (rd_idx == ofs_inten[11:2]) ||
    (rd_idx == ofs_irqf[11:2]) ||
    (rd_idx == ofs_stat[11:2]);

  wire live_traffic = !inhibit;
  wire bus_rst = bus_reset_evt && live_traffic;
  wire susp_go = suspend_evt && live_traffic && suspend_enable &&
    !suspend_mode;
  wire resume_go = resume_evt && live_traffic && suspend_mode;
  wire resume_end = wr_power && !w_data[`PWR_RESUME] && resume_drive;

  always @(posedge MCLK_I or negedge RESET_N_I)
  begin
    if (!RESET_N_I)
      soft_reset <= 1'b0;
    else
      soft_reset <= wr_power && w_data[`PWR_BUSRST] && !soft_reset;
  end

  always @(posedge MCLK_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      S_AXI_AWREADY_O <= 1'b1;
      S_AXI_WREADY_O <= 1'b1;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= 2'b00;
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RRESP_O <= 2'b00;
      S_AXI_RDATA_O <= 32'h00000000;
      {addr_pending, addr_written} <= `FUNC_RESET;
      ACTIVE_ADDRESS_O <= 7'h00;
      iso_enable <= 1'b0;
      inhibit <= 1'b1;
      busrst_flag <= 1'b0;
      resume_drive <= 1'b0;
      suspend_mode <= 1'b0;
      suspend_enable <= 1'b0;
      int_enable <= `INTEN_RESET;
      irq_flags <= 8'h00;
      resumed_by_host <= 1'b0;
      iso_waiting <= 1'b0;
      FUNCTION_ENABLE_O <= 1'b0;
      SUSPENDED_O <= 1'b0;
      OSC_WAKE_O <= 1'b0;
      REMOTE_WAKEUP_O <= 1'b0;
      ISO_SEND_PACKET_O <= 1'b0;
      ISO_ZERO_LENGTH_O <= 1'b0;
      FIFO_FLUSH_O <= 1'b0;
      EP_CSR_CLEAR_O <= 1'b0;
      INDEX_CLEAR_O <= 1'b0;
    end
    else
    begin
      // Bus channels
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
      begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I;
        S_AXI_AWREADY_O <= 1'b0;
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O)
      begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
        S_AXI_WREADY_O <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= wr_hit ? 2'b00 : 2'b10;
      end
      if (S_AXI_BVALID_O && S_AXI_BREADY_I)
      begin
        S_AXI_BVALID_O <= 1'b0;
        S_AXI_AWREADY_O <= 1'b1;
        S_AXI_WREADY_O <= 1'b1;
      end
      if (rd_go)
      begin
        S_AXI_ARREADY_O <= 1'b0;
        S_AXI_RVALID_O <= 1'b1;
        S_AXI_RDATA_O <= {24'h000000, rdata_mux};
        S_AXI_RRESP_O <= rd_hit ? 2'b00 : 2'b10;
      end
      if (S_AXI_RVALID_O && S_AXI_RREADY_I)
      begin
        S_AXI_RVALID_O <= 1'b0;
        S_AXI_ARREADY_O <= 1'b1;
      end

      // Function address: staged, applied at end of transfer
      if (wr_func)
      begin
        addr_written <= w_data[6:0];
        addr_pending <= 1'b1;
      end
      else if (addr_pending && TRANSFER_DONE_I)
      begin
        ACTIVE_ADDRESS_O <= addr_written;
        addr_pending <= 1'b0;
      end

      // Power register writes
      if (wr_power)
      begin
        iso_enable <= w_data[`PWR_ISO];
        suspend_enable <= w_data[`PWR_SUSPEND_DETECT_ENABLE];
        resume_drive <= w_data[`PWR_RESUME] && suspend_mode;
        if (!w_data[`PWR_INHIBIT])
          inhibit <= 1'b0;
      end
      if (wr_inten)
        int_enable <= w_data[7:0];

      // Flags: reading clears, a same-cycle event wins
      if (rd_irqf)
        irq_flags <= 8'h00;
      if (susp_go && int_enable[`IRQ_SUSP])
        irq_flags[`IRQ_SUSP] <= 1'b1;
      if (resume_go && int_enable[`IRQ_RESUME])
        irq_flags[`IRQ_RESUME] <= 1'b1;

      // Suspend status
      if (susp_go)
        suspend_mode <= 1'b1;
      if (resume_go)
        resumed_by_host <= 1'b1;
      if (resume_end || (rd_irqf && resumed_by_host))
      begin
        suspend_mode <= 1'b0;
        resumed_by_host <= 1'b0;
      end

      // Bus reset and its side effects, above all but a same-cycle iso packet load
      busrst_flag <= pin_level[0] || bus_reset_evt;
      if (bus_rst)
      begin
        busrst_flag <= 1'b1;
        addr_written <= 7'h00;
        ACTIVE_ADDRESS_O <= 7'h00;
        addr_pending <= 1'b0;
        suspend_mode <= 1'b0;
        resumed_by_host <= 1'b0;
        resume_drive <= 1'b0;
        int_enable <= `INTEN_BUSRST;
        irq_flags <= 8'h00;
        irq_flags[`IRQ_RESET] <= 1'b1;
        iso_waiting <= 1'b0;
      end
      FIFO_FLUSH_O <= bus_rst;
      EP_CSR_CLEAR_O <= bus_rst;
      INDEX_CLEAR_O <= bus_rst;

      // Isochronous IN timing
      ISO_SEND_PACKET_O <= 1'b0;
      ISO_ZERO_LENGTH_O <= 1'b0;
      // A packet loaded alongside a frame start waits for the next one
      if (SOF_I && iso_waiting)
        iso_waiting <= 1'b0;
      if (IN_PACKET_LOADED_I && iso_enable && live_traffic)
        iso_waiting <= 1'b1;
      if (ISO_IN_TOKEN_I && live_traffic)
      begin
        if (iso_enable && iso_waiting && !SOF_I)
          ISO_ZERO_LENGTH_O <= 1'b1;
        else
          ISO_SEND_PACKET_O <= 1'b1;
      end

      // Status outputs
      FUNCTION_ENABLE_O <= !inhibit;
      SUSPENDED_O <= suspend_mode;
      REMOTE_WAKEUP_O <= resume_drive;
      OSC_WAKE_O <= resume_go || bus_rst || (resume_drive &&
        !REMOTE_WAKEUP_O);
    end
  end

endmodule // usb_function_address_power_control

// ==== usb_fctl_properties.sv ====
// Checker for the function address and power control block
`timescale 1ns/1ps
module usb_fctl_checker (
  input wire MCLK_I,
  input wire RESET_N_I,
  input wire BUS_RESET_I,
  input wire BUS_SUSPEND_I,
  input wire TRANSFER_DONE_I,
  input wire ISO_IN_TOKEN_I,
  input wire [6:0] ACTIVE_ADDRESS_O,
  input wire FUNCTION_ENABLE_O,
  input wire SUSPENDED_O,
  input wire REMOTE_WAKEUP_O,
  input wire ISO_SEND_PACKET_O,
  input wire ISO_ZERO_LENGTH_O,
  input wire FIFO_FLUSH_O,
  input wire EP_CSR_CLEAR_O,
  input wire INDEX_CLEAR_O
);
  default clocking @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  // ----
  // Properties
  // ----
  a_addr_applies: assert property (
    (ACTIVE_ADDRESS_O != $past(ACTIVE_ADDRESS_O)) &&
    (ACTIVE_ADDRESS_O != 7'h00) |->
    $past(TRANSFER_DONE_I) || $past(TRANSFER_DONE_I, 2))
    else $error("address changed without transfer end");
  a_flush_group: assert property (
    FIFO_FLUSH_O |-> EP_CSR_CLEAR_O && INDEX_CLEAR_O)
    else $error("bus reset clears not together");
  a_flush_cause: assert property (
    $rose(FIFO_FLUSH_O) |-> $past(BUS_RESET_I, 2))
    else $error("flush without bus reset");
  a_inhibit_ignores: assert property (
    FIFO_FLUSH_O |-> FUNCTION_ENABLE_O)
    else $error("bus reset acted while inhibited");
  a_addr_cleared: assert property (
    FIFO_FLUSH_O |-> ##[0:1] ACTIVE_ADDRESS_O == 7'h00)
    else $error("address not cleared by bus reset");
  a_iso_cause: assert property (
    ISO_SEND_PACKET_O || ISO_ZERO_LENGTH_O |->
    $past(ISO_IN_TOKEN_I) || $past(ISO_IN_TOKEN_I, 2))
    else $error("iso answer without token");
  a_iso_exclusive: assert property (
    ISO_ZERO_LENGTH_O |-> !ISO_SEND_PACKET_O)
    else $error("iso packet and zero packet together");
  a_suspend_cause: assert property (
    $rose(SUSPENDED_O) |-> $past(BUS_SUSPEND_I, 2))
    else $error("suspend without bus suspend");
  a_wake_suspended: assert property (
    $rose(REMOTE_WAKEUP_O) |-> $past(SUSPENDED_O))
    else $error("remote wakeup outside suspend");
  cover property ($rose(FIFO_FLUSH_O));
  cover property ($rose(SUSPENDED_O));
  cover property (ISO_ZERO_LENGTH_O);
endmodule // usb_fctl_checker

bind usb_function_address_power_control usb_fctl_checker usb_fctl_checker_inst (
  .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .BUS_RESET_I(BUS_RESET_I),
  .BUS_SUSPEND_I(BUS_SUSPEND_I), .TRANSFER_DONE_I(TRANSFER_DONE_I),
  .ISO_IN_TOKEN_I(ISO_IN_TOKEN_I), .ACTIVE_ADDRESS_O(ACTIVE_ADDRESS_O),
  .FUNCTION_ENABLE_O(FUNCTION_ENABLE_O), .SUSPENDED_O(SUSPENDED_O),
  .REMOTE_WAKEUP_O(REMOTE_WAKEUP_O), .ISO_SEND_PACKET_O(ISO_SEND_PACKET_O),
  .ISO_ZERO_LENGTH_O(ISO_ZERO_LENGTH_O), .FIFO_FLUSH_O(FIFO_FLUSH_O),
  .EP_CSR_CLEAR_O(EP_CSR_CLEAR_O), .INDEX_CLEAR_O(INDEX_CLEAR_O));

// ==== usb_host_model.sv ====
// Behavioural USB host producing bus events
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  output logic bus_reset_o = 1'b0,
  output logic suspend_o = 1'b0,
  output logic resume_o = 1'b0,
  output logic done_o = 1'b0,
  output logic sof_o = 1'b0,
  output logic token_o = 1'b0
);
  // Levels are asynchronous at the block, so hold each for many cycles
  task automatic lines(input logic r, input logic s, input logic q);
    @(posedge clk_i);
    bus_reset_o <= r;
    suspend_o <= s;
    resume_o <= q;
  endtask
  // 0 transfer end, 1 start of frame, 2 iso IN token
  task automatic pulse(input int k);
    @(posedge clk_i);
    done_o <= (k == 0);
    sof_o <= (k == 1);
    token_o <= (k == 2);
    @(posedge clk_i);
    done_o <= 1'b0;
    sof_o <= 1'b0;
    token_o <= 1'b0;
  endtask
endmodule // usb_host_model

// ==== tb_usb_function_address_power_control.sv ====
// Testbench for the function address and power control block
`timescale 1ns/1ps
`include "usb_fctl_consts.vh"
module tb_usb_function_address_power_control;
  logic MCLK_I = 1'b0, RESET_N_I = 1'b0, IN_PACKET_LOADED_I = 1'b0;
  logic [11:0] S_AXI_AWADDR_I = 12'h000, S_AXI_ARADDR_I = 12'h000;
  logic [31:0] S_AXI_WDATA_I = 32'h0, S_AXI_RDATA_O;
  logic [3:0] S_AXI_WSTRB_I = 4'hF;
  logic S_AXI_AWVALID_I = 1'b0, S_AXI_WVALID_I = 1'b0, S_AXI_BREADY_I = 1'b0;
  logic S_AXI_ARVALID_I = 1'b0, S_AXI_RREADY_I = 1'b0;
  logic S_AXI_AWREADY_O, S_AXI_WREADY_O, S_AXI_BVALID_O, S_AXI_ARREADY_O;
  logic S_AXI_RVALID_O, FUNCTION_ENABLE_O, SUSPENDED_O, OSC_WAKE_O;
  logic [1:0] S_AXI_BRESP_O, S_AXI_RRESP_O;
  logic BUS_RESET_I, BUS_SUSPEND_I, BUS_RESUME_I, TRANSFER_DONE_I, SOF_I;
  logic ISO_IN_TOKEN_I, REMOTE_WAKEUP_O, ISO_SEND_PACKET_O, ISO_ZERO_LENGTH_O;
  logic FIFO_FLUSH_O, EP_CSR_CLEAR_O, INDEX_CLEAR_O;
  logic [6:0] ACTIVE_ADDRESS_O;
  int err_count = 0, n_tests = 0, cnt_flush = 0, cnt_osc = 0;
  int cnt_zero = 0, cnt_send = 0;
  usb_function_address_power_control usb_function_address_power_control_inst (
    .MCLK_I(MCLK_I), .RESET_N_I(RESET_N_I), .S_AXI_AWADDR_I(S_AXI_AWADDR_I),
    .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WDATA_I(S_AXI_WDATA_I), .S_AXI_WSTRB_I(S_AXI_WSTRB_I),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O),
    .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
    .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARADDR_I(S_AXI_ARADDR_I),
    .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
    .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I),
    .BUS_RESET_I(BUS_RESET_I), .BUS_SUSPEND_I(BUS_SUSPEND_I),
    .BUS_RESUME_I(BUS_RESUME_I), .TRANSFER_DONE_I(TRANSFER_DONE_I),
    .SOF_I(SOF_I), .ISO_IN_TOKEN_I(ISO_IN_TOKEN_I),
    .IN_PACKET_LOADED_I(IN_PACKET_LOADED_I),
    .ACTIVE_ADDRESS_O(ACTIVE_ADDRESS_O), .FUNCTION_ENABLE_O(FUNCTION_ENABLE_O),
    .SUSPENDED_O(SUSPENDED_O), .OSC_WAKE_O(OSC_WAKE_O),
    .REMOTE_WAKEUP_O(REMOTE_WAKEUP_O), .ISO_SEND_PACKET_O(ISO_SEND_PACKET_O),
    .ISO_ZERO_LENGTH_O(ISO_ZERO_LENGTH_O), .FIFO_FLUSH_O(FIFO_FLUSH_O),
    .EP_CSR_CLEAR_O(EP_CSR_CLEAR_O), .INDEX_CLEAR_O(INDEX_CLEAR_O));
  usb_host_model usb_host_model_inst (
    .clk_i(MCLK_I), .bus_reset_o(BUS_RESET_I), .suspend_o(BUS_SUSPEND_I),
    .resume_o(BUS_RESUME_I), .done_o(TRANSFER_DONE_I), .sof_o(SOF_I),
    .token_o(ISO_IN_TOKEN_I));
  initial
  begin
    forever #5 MCLK_I = ~MCLK_I;
  end
  // Pulse outputs last one cycle, so tally them at every edge
  always @(posedge MCLK_I)
  begin
    cnt_flush <= cnt_flush + (FIFO_FLUSH_O & EP_CSR_CLEAR_O & INDEX_CLEAR_O);
    cnt_osc <= cnt_osc + (OSC_WAKE_O === 1'b1);
    cnt_zero <= cnt_zero + (ISO_ZERO_LENGTH_O === 1'b1);
    cnt_send <= cnt_send + (ISO_SEND_PACKET_O === 1'b1);
  end
  // ----
  // Shared tasks
  // ----
  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge MCLK_I);
  endtask
  task automatic tmo(input int n);
    if (n >= 40)
    begin
      err_count++;
      results;
    end
  endtask
  // A soft reset may swallow its own write response, so sr stops waiting
  // Ready lines stay low from the handshake until the response, so back-to-back calls
  // never assign them twice in one step
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input bit sr = 0);
    int n;
    n = 0;
    S_AXI_AWADDR_I <= a;
    S_AXI_WDATA_I <= d;
    S_AXI_AWVALID_I <= 1'b1;
    S_AXI_WVALID_I <= 1'b1;
    S_AXI_BREADY_I <= 1'b1;
    do
    begin
      @(posedge MCLK_I);
      n++;
      if (S_AXI_AWREADY_O === 1'b1) S_AXI_AWVALID_I <= 1'b0;
      if (S_AXI_WREADY_O === 1'b1) S_AXI_WVALID_I <= 1'b0;
    end while (S_AXI_BVALID_O !== 1'b1 && !(sr && n > 4) && n < 40);
    tmo(n);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_ARADDR_I <= a;
    S_AXI_ARVALID_I <= 1'b1;
    S_AXI_RREADY_I <= 1'b1;
    do
    begin
      @(posedge MCLK_I);
      n++;
      if (S_AXI_ARREADY_O === 1'b1) S_AXI_ARVALID_I <= 1'b0;
    end while (S_AXI_RVALID_O !== 1'b1 && n < 40);
    d = S_AXI_RDATA_O;
    r = S_AXI_RRESP_O;
    tmo(n);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_defaults;
    logic [31:0] d;
    logic [1:0] r;
    rdc(`ADDR_FUNC, 32'h00);
    rdc(`ADDR_POWER, 32'h10);
    chk(FUNCTION_ENABLE_O, 1'b0);
    rd(12'h040, d, r);
    chk({d[29:0], r}, 32'h2);
    S_AXI_WSTRB_I <= 4'h0;
    wr(`ADDR_FUNC, 32'h55);
    chk(S_AXI_BRESP_O, 2'b00);
    S_AXI_WSTRB_I <= 4'hF;
    rdc(`ADDR_FUNC, 32'h00);
    wr(12'h040, 32'h55);
    chk(S_AXI_BRESP_O, 2'b10);
  endtask
  task automatic t_address;
    wr(`ADDR_POWER, 32'h00);
    wr(`ADDR_POWER, 32'h10);
    rdc(`ADDR_POWER, 32'h00);
    chk(FUNCTION_ENABLE_O, 1'b1);
    wr(`ADDR_FUNC, 32'hFF);
    rdc(`ADDR_FUNC, 32'hFF);
    chk(ACTIVE_ADDRESS_O, 7'h00);
    usb_host_model_inst.pulse(0);
    cyc(2);
    chk(ACTIVE_ADDRESS_O, 7'h7F);
    rdc(`ADDR_FUNC, 32'h7F);
  endtask
  task automatic t_bus_reset(input int exp);
    int o;
    o = cnt_flush;
    usb_host_model_inst.lines(1'b1, 1'b0, 1'b0);
    cyc(6);
    if (exp) rdc(`ADDR_POWER, 32'h08);
    usb_host_model_inst.lines(1'b0, 1'b0, 1'b0);
    cyc(2);
    chk(cnt_flush - o, exp);
    chk(ACTIVE_ADDRESS_O, 7'h00);
    if (exp) rdc(`ADDR_INTEN, {24'h0, `INTEN_BUSRST});
  endtask
  task automatic t_soft_reset;
    wr(`ADDR_FUNC, 32'h15);
    usb_host_model_inst.pulse(0);
    wr(`ADDR_POWER, 32'h08, 1'b1);
    cyc(3);
    rdc(`ADDR_POWER, 32'h10);
    rdc(`ADDR_FUNC, 32'h00);
    chk(FUNCTION_ENABLE_O, 1'b0);
  endtask
  task automatic t_suspend;
    int o;
    o = cnt_osc;
    wr(`ADDR_INTEN, 32'h03);
    wr(`ADDR_POWER, 32'h01);
    usb_host_model_inst.lines(1'b0, 1'b1, 1'b0);
    cyc(8);
    chk(SUSPENDED_O, 1'b1);
    rdc(`ADDR_IRQF, 32'h01);
    rdc(`ADDR_POWER, 32'h03);
    usb_host_model_inst.lines(1'b0, 1'b0, 1'b1);
    cyc(8);
    rdc(`ADDR_IRQF, 32'h02);
    cyc(1);
    chk(SUSPENDED_O, 1'b0);
    usb_host_model_inst.lines(1'b0, 1'b1, 1'b0);
    cyc(8);
    wr(`ADDR_POWER, 32'h05);
    cyc(1);
    chk(REMOTE_WAKEUP_O, 1'b1);
    wr(`ADDR_POWER, 32'h01);
    cyc(1);
    chk(REMOTE_WAKEUP_O, 1'b0);
    chk(SUSPENDED_O, 1'b0);
    chk(cnt_osc - o, 2);
    usb_host_model_inst.lines(1'b0, 1'b0, 1'b0);
  endtask
  task automatic t_iso;
    int z;
    z = cnt_zero;
    wr(`ADDR_POWER, 32'h80);
    IN_PACKET_LOADED_I <= 1'b1;
    cyc(1);
    IN_PACKET_LOADED_I <= 1'b0;
    usb_host_model_inst.pulse(2);
    cyc(3);
    chk(cnt_zero - z, 1);
    chk(cnt_send, 0);
    usb_host_model_inst.pulse(1);
    usb_host_model_inst.pulse(2);
    cyc(3);
    chk(cnt_send, 1);
  endtask
  initial
  begin
    repeat (10) @(posedge MCLK_I);
    RESET_N_I <= 1'b1;
    @(posedge MCLK_I);
    t_defaults;
    t_address;
    t_bus_reset(1);
    t_soft_reset;
    t_bus_reset(0);
    t_suspend;
    t_iso;
    results;
  end
endmodule // tb_usb_function_address_power_control
